// ===== scsi_irq_fifo_buffer_regs.sv
// scsi interrupt enable 2, fifo port, buffer data and buffer status/control registers
// What this block does
// [RULE_01] reset pin or host/buffer reset clears the interrupt enable 2 register
// [RULE_02] enable bit 0 with chosen-as-target flag drives host interrupt low
// [RULE_03] enable bit 1 with re-chosen-as-initiator flag drives host interrupt low
// [RULE_04] enable bit 2 with arbitration-won flag drives host interrupt low
// [RULE_05] enable bit 3 with auto selection complete flag drives host interrupt low
// [RULE_06] enable bit 4 with transfer-complete flag drives host interrupt low
// [RULE_07] enable bit 5 with transfer-stopped flag drives host interrupt low
// [RULE_08] enable bit 6 with bus phase wrong flag drives host interrupt low
// [RULE_09] enable bit 7 with request-seen flag drives host interrupt low
// [RULE_10] fifo port write pushes the byte, read returns fifo output byte
// [RULE_11] fifo port data has no reset value
// [RULE_12] buffer data port reads or writes buffer memory at disk pointer
// [RULE_13] with buffer output enable off, buffer reads return switch levels
// [RULE_14] buffer data and control registers clear on either reset
// [RULE_15] control bits 0-3 read back the running synchronous offset
// [RULE_16] setting clear-fifo resets the scsi fifo before fifo use
// [RULE_17] async set-up select picks one or two clock periods of set-up
// [RULE_18] dram burst bit makes page accesses bursts of four, last shorter
// [RULE_19] software keeps burst bit zero in sram or small-offset initiator mode
// [RULE_20] software keeps control bit 7 cleared, it is for test
// [RULE_21] status 2 flags clear only by writing one, withdrawing the interrupt
// [RULE_22] host interrupt stays low while any enabled pair is active
`timescale 1ns/10ps
module scsi_irq_fifo_buffer_regs
  import scsi_irq_fifo_buffer_regs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic host_buf_reset,
  input wire mcu_bus_type mcu_bus,
  output logic [7:0] ad_out,
  output logic ad_oe,
  input wire logic [7:0] status2_flags,
  output logic [7:0] status2_clear,
  output logic host_irq_n,
  output logic fifo_push,
  output logic [7:0] fifo_wdata,
  output logic fifo_pop,
  input wire logic [7:0] fifo_rdata,
  output logic fifo_clear,
  output logic buf_write,
  output logic buf_read_req,
  input wire logic buf_rd_valid,
  input wire logic [7:0] buf_rdata,
  input wire logic [7:0] switch_levels,
  input wire logic buffer_output_enable_off,
  input wire logic [3:0] sync_offset,
  output logic async_setup_double,
  output logic dram_burst_en,
  input wire logic setup_start,
  output logic setup_done,
  input wire logic [7:0] words_left,
  output logic [2:0] burst_len
);
  logic [7:0] addr;
  logic prev_rd_n;
  logic prev_wr_n;
  logic [7:0] irq_enable;
  logic [7:0] buffer_data;
  logic [7:0] control;
  setup_state_type setup_state;
  logic [7:0] next_addr;
  logic [7:0] next_irq_enable;
  logic [7:0] next_buffer_data;
  logic [7:0] next_control;
  logic [7:0] next_ad_out;
  logic next_ad_oe;
  logic [7:0] next_status2_clear;
  logic next_host_irq_n;
  logic next_fifo_push;
  logic next_fifo_pop;
  logic next_fifo_clear;
  logic next_buf_write;
  logic next_buf_read_req;
  logic next_setup_done;
  logic [2:0] next_burst_len;
  setup_state_type next_setup_state;
  logic wr_start;
  logic rd_start;
  logic rd_end;
  logic reading;

  // strobe edges on the sampled bus
  assign wr_start = prev_wr_n & ~mcu_bus.wr_n;
  assign rd_start = prev_rd_n & ~mcu_bus.rd_n;
  assign rd_end = ~prev_rd_n & mcu_bus.rd_n;
  assign reading = ~mcu_bus.rd_n;

  // register file next values
  always_comb begin
    next_addr = mcu_bus.ale ? mcu_bus.ad : addr;
    next_irq_enable = irq_enable;
    next_buffer_data = buffer_data;
    next_control = control;
    next_status2_clear = 8'h00;
    next_fifo_push = 1'b0;
    next_fifo_pop = 1'b0;
    next_fifo_clear = 1'b0;
    next_buf_write = 1'b0;
    next_buf_read_req = 1'b0;
    if (buf_rd_valid) begin
      next_buffer_data = buf_rdata; // [RULE_12]
    end
    if (wr_start) begin
      unique case (addr)
        status2_clear_addr: begin
          next_status2_clear = mcu_bus.ad; // write-one clear strobe [RULE_21]
        end
        scsi_event_irq_enable_2_addr: begin
          next_irq_enable = mcu_bus.ad;
        end
        scsi_fifo_byte_port_addr: begin
          next_fifo_push = 1'b1; // [RULE_10]
        end
        buffer_memory_data_port_addr: begin
          next_buffer_data = mcu_bus.ad; // [RULE_12]
          next_buf_write = 1'b1;
        end
        buffer_offset_and_control_addr: begin
          next_control = {mcu_bus.ad[7:4], 4'h0};
          next_fifo_clear = mcu_bus.ad[clear_fifo_bit]; // [RULE_16]
        end
        default: begin
        end
      endcase
    end
    if (rd_start && addr == buffer_memory_data_port_addr && !buffer_output_enable_off) begin
      next_buf_read_req = 1'b1; // [RULE_12]
    end
    if (rd_end && addr == scsi_fifo_byte_port_addr) begin
      next_fifo_pop = 1'b1; // advance fifo after the byte was read [RULE_10]
    end
    if (host_buf_reset) begin
      next_irq_enable = irq_enable_reset; // [RULE_01]
      next_buffer_data = buffer_data_reset; // [RULE_14]
      next_control = control_reset; // [RULE_14]
    end
  end

  // read mux, registered onto the bus
  always_comb begin
    next_ad_oe = reading;
    next_ad_out = unmapped_read_value;
    if (reading) begin
      unique case (addr)
        scsi_event_irq_enable_2_addr: next_ad_out = irq_enable;
        scsi_fifo_byte_port_addr: next_ad_out = fifo_rdata; // [RULE_10]
        buffer_memory_data_port_addr: begin
          next_ad_out = buffer_output_enable_off ? switch_levels : buffer_data; // [RULE_13]
        end
        buffer_offset_and_control_addr: begin
          next_ad_out = {control[7:4], sync_offset}; // [RULE_15]
        end
        default: next_ad_out = unmapped_read_value;
      endcase
    end
  end

  // interrupt gating and burst sizing
  always_comb begin
    next_host_irq_n = ~|(irq_enable & status2_flags); // [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_22]
    if (control[dram_burst_bit]) begin
      next_burst_len = (words_left < 8'(burst_full_len)) ? words_left[2:0] : burst_full_len; // [RULE_18]
    end else begin
      next_burst_len = burst_single_len; // [RULE_18]
    end
  end

  // async data set-up timer
  always_comb begin
    next_setup_state = setup_state;
    next_setup_done = 1'b0;
    unique case (setup_state)
      st_idle: begin
        if (setup_start) begin
          if (control[async_setup_double_bit]) begin
            next_setup_state = st_wait; // [RULE_17]
          end else begin
            next_setup_done = 1'b1; // [RULE_17]
          end
        end
      end
      st_wait: begin
        next_setup_state = st_idle;
        next_setup_done = 1'b1; // [RULE_17]
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr <= 8'h00;
      prev_rd_n <= 1'b1;
      prev_wr_n <= 1'b1;
      irq_enable <= irq_enable_reset; // [RULE_01]
      buffer_data <= buffer_data_reset; // [RULE_14]
      control <= control_reset; // [RULE_14]
      setup_state <= st_idle;
      ad_out <= 8'h00;
      ad_oe <= 1'b0;
      status2_clear <= 8'h00;
      host_irq_n <= 1'b1;
      fifo_push <= 1'b0;
      fifo_pop <= 1'b0;
      fifo_clear <= 1'b0;
      buf_write <= 1'b0;
      buf_read_req <= 1'b0;
      async_setup_double <= 1'b0;
      dram_burst_en <= 1'b0;
      setup_done <= 1'b0;
      burst_len <= burst_single_len;
    end else begin
      addr <= next_addr;
      prev_rd_n <= mcu_bus.rd_n;
      prev_wr_n <= mcu_bus.wr_n;
      irq_enable <= next_irq_enable;
      buffer_data <= next_buffer_data;
      control <= next_control;
      setup_state <= next_setup_state;
      ad_out <= next_ad_out;
      ad_oe <= next_ad_oe;
      status2_clear <= next_status2_clear;
      host_irq_n <= next_host_irq_n; // [RULE_06] [RULE_07] [RULE_08] [RULE_09]
      fifo_push <= next_fifo_push;
      fifo_pop <= next_fifo_pop;
      fifo_clear <= next_fifo_clear;
      buf_write <= next_buf_write;
      buf_read_req <= next_buf_read_req;
      async_setup_double <= next_control[async_setup_double_bit];
      dram_burst_en <= next_control[dram_burst_bit];
      setup_done <= next_setup_done;
      burst_len <= next_burst_len;
    end
  end

  // fifo write byte, deliberately without reset [RULE_11]
  always_ff @(posedge clk) begin
    if (wr_start && addr == scsi_fifo_byte_port_addr) begin
      fifo_wdata <= mcu_bus.ad; // [RULE_10]
    end
  end

  // checks
  a_irq_assert: assert property (@(posedge clk) disable iff (!nrst) // [RULE_02] [RULE_03] [RULE_04] [RULE_05]
    (|(irq_enable & status2_flags)) |=> !host_irq_n) // [RULE_06] [RULE_07] [RULE_08] [RULE_09]
    else $error("host interrupt not asserted for enabled event");
  a_irq_release: assert property (@(posedge clk) disable iff (!nrst) // [RULE_22]
    (~|(irq_enable & status2_flags)) |=> host_irq_n)
    else $error("host interrupt low with no enabled event");
  a_enable_softreset: assert property (@(posedge clk) disable iff (!nrst) // [RULE_01]
    host_buf_reset |=> irq_enable == irq_enable_reset)
    else $error("interrupt enable not cleared by host/buffer reset");
  a_control_softreset: assert property (@(posedge clk) disable iff (!nrst) // [RULE_14]
    host_buf_reset |=> control == control_reset && buffer_data == buffer_data_reset && !dram_burst_en)
    else $error("buffer registers not cleared by host/buffer reset");
  a_fifo_push_byte: assert property (@(posedge clk) disable iff (!nrst) // [RULE_10]
    (wr_start && addr == scsi_fifo_byte_port_addr) |=> fifo_push && fifo_wdata == $past(mcu_bus.ad))
    else $error("fifo port write did not push the byte");
  a_fifo_read_byte: assert property (@(posedge clk) disable iff (!nrst) // [RULE_10]
    (reading && addr == scsi_fifo_byte_port_addr) |=> ad_oe && ad_out == $past(fifo_rdata))
    else $error("fifo port read returned wrong byte");
  a_idle_bus: assert property (@(posedge clk) disable iff (!nrst) // [RULE_10]
    !reading |=> !ad_oe && ad_out == unmapped_read_value)
    else $error("read data driven while not reading");
  a_switch_read: assert property (@(posedge clk) disable iff (!nrst) // [RULE_13]
    (reading && addr == buffer_memory_data_port_addr && buffer_output_enable_off)
      |=> ad_out == $past(switch_levels))
    else $error("switch levels not returned");
  a_offset_read: assert property (@(posedge clk) disable iff (!nrst) // [RULE_15]
    (reading && addr == buffer_offset_and_control_addr)
      |=> ad_out[offset_msb:offset_lsb] == $past(sync_offset))
    else $error("running offset not returned");
  a_fifo_clear_pulse: assert property (@(posedge clk) disable iff (!nrst) // [RULE_16]
    (wr_start && addr == buffer_offset_and_control_addr && mcu_bus.ad[clear_fifo_bit])
      |=> fifo_clear ##1 !fifo_clear)
    else $error("clear fifo did not pulse");
  a_setup_double: assert property (@(posedge clk) disable iff (!nrst) // [RULE_17]
    (setup_start && setup_state == st_idle && control[async_setup_double_bit])
      |=> !setup_done ##1 setup_done)
    else $error("double set-up not two periods");
  a_setup_single: assert property (@(posedge clk) disable iff (!nrst) // [RULE_17]
    (setup_start && setup_state == st_idle && !control[async_setup_double_bit]) |=> setup_done)
    else $error("single set-up not one period");
  a_burst_len: assert property (@(posedge clk) disable iff (!nrst) // [RULE_18]
    (control[dram_burst_bit] && words_left >= 8'(burst_full_len)) |=> burst_len == burst_full_len)
    else $error("burst length not four");
  a_short_burst: assert property (@(posedge clk) disable iff (!nrst) // [RULE_18]
    (control[dram_burst_bit] && words_left < 8'(burst_full_len)) |=> burst_len == 3'($past(words_left)))
    else $error("final burst length not the words left");
  a_buf_write: assert property (@(posedge clk) disable iff (!nrst) // [RULE_12]
    (wr_start && addr == buffer_memory_data_port_addr && !host_buf_reset)
      |=> buf_write && buffer_data == $past(mcu_bus.ad))
    else $error("buffer write not issued");
  a_status_clear: assert property (@(posedge clk) disable iff (!nrst) // [RULE_21]
    (wr_start && addr == status2_clear_addr) |=> status2_clear == $past(mcu_bus.ad))
    else $error("status clear strobe does not carry the written mask");
  c_irq_seen: cover property (@(posedge clk) disable iff (!nrst) $fell(host_irq_n));
  c_buffer_fetch: cover property (@(posedge clk) disable iff (!nrst) buf_read_req ##[1:4] buf_rd_valid);
  c_fifo_cycle: cover property (@(posedge clk) disable iff (!nrst) fifo_push ##[1:50] fifo_pop);
  c_double_setup: cover property (@(posedge clk) disable iff (!nrst) setup_state == st_wait ##1 setup_done);
  c_short_burst: cover property (@(posedge clk) disable iff (!nrst) dram_burst_en && burst_len < burst_full_len);
endmodule : scsi_irq_fifo_buffer_regs

// ===== scsi_irq_fifo_buffer_regs_pkg.sv
// constants and types for the scsi interrupt, fifo and buffer register slice
package scsi_irq_fifo_buffer_regs_pkg;
  // register byte addresses on the multiplexed bus
  localparam logic [7:0] status2_clear_addr = 8'h48;
  localparam logic [7:0] scsi_event_irq_enable_2_addr = 8'h49;
  localparam logic [7:0] scsi_fifo_byte_port_addr = 8'h4a;
  localparam logic [7:0] buffer_memory_data_port_addr = 8'h50;
  localparam logic [7:0] buffer_offset_and_control_addr = 8'h51;
  // reset values, and the value read from unmapped addresses
  localparam logic [7:0] irq_enable_reset = 8'h00;
  localparam logic [7:0] buffer_data_reset = 8'h00;
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] unmapped_read_value = 8'h00;
  // field positions in buffer_offset_and_control
  localparam int offset_lsb = 0;
  localparam int offset_msb = 3;
  localparam int clear_fifo_bit = 4;
  localparam int async_setup_double_bit = 5;
  localparam int dram_burst_bit = 6;
  localparam int test_bit = 7;
  // data set-up in clock periods for each select value
  localparam int setup_single_cycles = 1;
  localparam int setup_double_cycles = 2;
  // dram page-mode burst length when bursting, and the single-access length when not
  localparam logic [2:0] burst_full_len = 3'h4;
  localparam logic [2:0] burst_single_len = 3'h1;

  // microcontroller bus pins, sampled on clk
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [7:0] ad;
  } mcu_bus_type;

  // async set-up timer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01
  } setup_state_type;
endpackage : scsi_irq_fifo_buffer_regs_pkg

// ===== scsi_mcu_model.sv
// microcontroller model driving the multiplexed address/data bus
`timescale 1ns/10ps
module scsi_mcu_model
  import scsi_irq_fifo_buffer_regs_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] ad_out,
  output mcu_bus_type bus
);
  initial bus = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad: 8'h00};

  // address phase, then one write strobe held over two sampling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{ale: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ad: a};
    @(posedge clk) bus <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b0, ad: d};
    @(posedge clk);
    @(posedge clk) bus <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad: ~d};
  endtask : wr

  // long read strobe so a memory answer reaches the data pins; data taken at the last low edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) bus <= '{ale: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ad: a};
    @(posedge clk) bus <= '{ale: 1'b0, rd_n: 1'b0, wr_n: 1'b1, ad: ~a};
    repeat (6) @(posedge clk);
    d = ad_out;
    bus <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad: a};
  endtask : rd
endmodule : scsi_mcu_model

// ===== scsi_irq_fifo_buffer_regs_tb_top.sv
// self-checking bench for the scsi interrupt, fifo and buffer register slice
`timescale 1ns/10ps
module scsi_irq_fifo_buffer_regs_tb_top
  import scsi_irq_fifo_buffer_regs_pkg::*;
  ;
  logic clk, nrst, host_buf_reset, buffer_output_enable_off, setup_start, mem_on;
  logic buf_rd_valid = 1'b0;
  logic [7:0] status2_flags = 8'h00;
  logic [7:0] flag_set, fifo_rdata, buf_rdata, switch_levels, words_left, v, b;
  logic [3:0] sync_offset;
  mcu_bus_type mcu_bus;
  logic [7:0] ad_out, status2_clear, fifo_wdata;
  logic ad_oe, host_irq_n, fifo_push, fifo_pop, fifo_clear, buf_write, buf_read_req;
  logic async_setup_double, dram_burst_en, setup_done;
  logic [2:0] burst_len;
  int failures = 0, checks = 0, push_cnt = 0, pop_cnt = 0, clr_cnt = 0, bw_cnt = 0, n;

  scsi_irq_fifo_buffer_regs scsi_irq_fifo_buffer_regs_i (.clk, .nrst, .host_buf_reset, .mcu_bus, .ad_out,
    .ad_oe, .status2_flags, .status2_clear, .host_irq_n, .fifo_push, .fifo_wdata, .fifo_pop, .fifo_rdata,
    .fifo_clear, .buf_write, .buf_read_req, .buf_rd_valid, .buf_rdata, .switch_levels,
    .buffer_output_enable_off, .sync_offset, .async_setup_double, .dram_burst_en, .setup_start,
    .setup_done, .words_left, .burst_len);
  scsi_mcu_model scsi_mcu_model_i (.clk(clk), .ad_out(ad_out), .bus(mcu_bus));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // far side: write-one-clear flags, one-word buffer memory, pulse counters
  always @(posedge clk) begin
    status2_flags <= (status2_flags & ~status2_clear) | flag_set;
    buf_rd_valid <= buf_read_req & mem_on;
    push_cnt <= push_cnt + int'(fifo_push);
    pop_cnt <= pop_cnt + int'(fifo_pop);
    clr_cnt <= clr_cnt + int'(fifo_clear);
    bw_cnt <= bw_cnt + int'(buf_write);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    scsi_mcu_model_i.rd(a, v);
    chk(v, exp);
  endtask : rchk

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic raise(input logic [7:0] f);
    @(posedge clk) flag_set <= f;
    @(posedge clk) flag_set <= 8'h00;
    settle;
  endtask : raise

  task automatic setup_len(input int exp);
    @(posedge clk) setup_start <= 1'b1;
    @(posedge clk) setup_start <= 1'b0;
    #1;
    n = 1;
    while (setup_done !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), 8'(exp));
  endtask : setup_len

  task automatic t_irq;
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      scsi_mcu_model_i.wr(8'h49, b);
      raise(~b);
      chk(8'(host_irq_n), 8'h01);
      raise(b);
      chk(8'(host_irq_n), 8'h00);
      scsi_mcu_model_i.wr(8'h49, 8'h00);
      settle;
      chk(8'(host_irq_n), 8'h01);
      scsi_mcu_model_i.wr(8'h49, b);
      scsi_mcu_model_i.wr(8'h48, b);
      settle;
      chk(8'(host_irq_n), 8'h01);
      chk(status2_flags, ~b);
      scsi_mcu_model_i.wr(8'h48, 8'hff);
    end
    settle;
    chk(status2_flags, 8'h00);
    rchk(8'h49, 8'h80);
  endtask : t_irq

  task automatic t_fifo;
    scsi_mcu_model_i.wr(8'h51, 8'h10);
    settle;
    chk(8'(clr_cnt), 8'h01);
    scsi_mcu_model_i.wr(8'h4a, 8'h96);
    scsi_mcu_model_i.wr(8'h4a, 8'h69);
    settle;
    chk(8'(push_cnt), 8'h02);
    chk(fifo_wdata, 8'h69);
    rchk(8'h4a, 8'h5a);
    chk(8'(ad_oe), 8'h01);
    settle;
    chk(8'(pop_cnt), 8'h01);
    chk(8'(ad_oe), 8'h00);
  endtask : t_fifo

  task automatic t_buffer;
    scsi_mcu_model_i.wr(8'h50, 8'hc3);
    settle;
    chk(8'(bw_cnt), 8'h01);
    rchk(8'h50, 8'hc3);
    buffer_output_enable_off <= 1'b1;
    rchk(8'h50, 8'ha5);
    buffer_output_enable_off <= 1'b0;
    mem_on <= 1'b1;
    rchk(8'h50, 8'h3c);
    mem_on <= 1'b0;
  endtask : t_buffer

  task automatic t_control;
    sync_offset <= 4'hf;
    scsi_mcu_model_i.wr(8'h51, 8'h7f);
    settle;
    chk(8'(clr_cnt), 8'h02);
    chk(8'({dram_burst_en, async_setup_double}), 8'h03);
    rchk(8'h51, 8'h7f);
    setup_len(setup_double_cycles);
    @(posedge clk) words_left <= 8'h02;
    settle;
    chk(8'(burst_len), 8'h02);
    @(posedge clk) words_left <= 8'h09;
    settle;
    chk(8'(burst_len), 8'(burst_full_len));
    scsi_mcu_model_i.wr(8'h51, 8'h00);
    settle;
    chk(8'({dram_burst_en, async_setup_double}), 8'h00);
    setup_len(setup_single_cycles);
    chk(8'(burst_len), 8'(burst_single_len));
  endtask : t_control

  task automatic t_soft_reset;
    scsi_mcu_model_i.wr(8'h49, 8'hff);
    scsi_mcu_model_i.wr(8'h51, 8'h60);
    scsi_mcu_model_i.wr(8'h50, 8'h77);
    @(posedge clk) host_buf_reset <= 1'b1;
    @(posedge clk) host_buf_reset <= 1'b0;
    sync_offset <= 4'h0;
    rchk(8'h49, irq_enable_reset);
    rchk(8'h51, control_reset);
    rchk(8'h50, buffer_data_reset);
  endtask : t_soft_reset

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end

  initial begin
    nrst = 1'b0;
    host_buf_reset = 1'b0;
    setup_start = 1'b0;
    mem_on = 1'b0;
    flag_set = 8'h00;
    fifo_rdata = 8'h5a;
    buf_rdata = 8'h3c;
    switch_levels = 8'ha5;
    buffer_output_enable_off = 1'b0;
    sync_offset = 4'h0;
    words_left = 8'h09;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rchk(8'h49, irq_enable_reset);
    rchk(8'h51, control_reset);
    rchk(8'h50, buffer_data_reset);
    t_irq;
    t_fifo;
    t_buffer;
    t_control;
    t_soft_reset;
    report_and_stop;
  end
endmodule : scsi_irq_fifo_buffer_regs_tb_top
